// ===== src/dict_instruction_timing.sv
// How it works
// - branches, calls, return: 4 cycles, delayed 2
// - pointer-nonzero branch: two words, 4/2/2 cycles
// - conditional transfers: 4, delayed 2, failed 2
// - context returns and interrupts take 4 cycles
// - conditional execute: one word, one cycle
// - data-to-data move: 2 or 3 cycles
// - data-to-program move: one word, 2 cycles
// - program-to-data move: 2 or 3 cycles
// - port in 2, port out 3, two words
// - mapped register: core 2, peripheral 3
// - data move: one word, one cycle
// - indirect bit test: one word, one cycle
// - accumulator push/pop: one word, one cycle
// - memory push/pop: one word, one cycle
// - repeats take 2; clear form zeroes registers
// - external write two cycles, read one
// - write after or with a read stretches to three
// - single-access block clash adds one cycle
// - external accesses add programmed wait states
module dict_instruction_timing
  import dict_pkg::*;
#(
  parameter int WAIT_W = WAIT_WIDTH
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              issueValid,
  input  dict_instr_type         issueInstr,
  input  wire logic [WAIT_W-1:0] progWait,
  input  wire logic [WAIT_W-1:0] dataWait,
  input  wire logic [WAIT_W-1:0] ioWait,
  input  wire logic              extProgFetch,
  output logic                   issueReady,
  output logic                   doneValid,
  output logic [3:0]             doneCycles,
  output logic [1:0]             doneWords,
  output logic                   transferNow,
  output logic                   clearAccProd,
  output logic                   enableIrq,
  output logic                   condExecNext,
  output logic                   busy
);

  // --------------------------------------------------------------------
  // base timing lookup
  // --------------------------------------------------------------------
  function automatic dict_timing_type baseTiming(dict_instr_type ins);
    dict_timing_type t;
    t = '{words: WORDS_ONE, cycles: CYC_ONE, flushSlots: 1'b0,
          clearAccProd: 1'b0, enableIrq: 1'b0};
    case (ins.op)
      OP_BRANCH, OP_CALL: begin
        t.words  = WORDS_TWO;
        t.cycles = ins.delayed ? CYC_TWO : CYC_FOUR;
        t.flushSlots = ins.delayed;
      end
      OP_BRANCH_ACC, OP_CALL_ACC, OP_RETURN: begin
        t.cycles = ins.delayed ? CYC_TWO : CYC_FOUR;
        t.flushSlots = ins.delayed;
      end
      OP_BRANCH_PTR_NZ, OP_BRANCH_COND, OP_CALL_COND: begin
        t.words  = WORDS_TWO;
        t.cycles = (ins.condTrue && !ins.delayed) ? CYC_FOUR : CYC_TWO;
        t.flushSlots = ins.delayed && ins.condTrue;
      end
      OP_RETURN_COND: begin
        t.cycles = (ins.condTrue && !ins.delayed) ? CYC_FOUR : CYC_TWO;
        t.flushSlots = ins.delayed && ins.condTrue;
      end
      OP_RETURN_CTX, OP_SOFT_INT, OP_NMI: begin
        t.cycles = CYC_FOUR;
      end
      OP_RETURN_CTX_IRQ: begin
        t.cycles    = CYC_FOUR;
        t.enableIrq = 1'b1;
      end
      OP_COND_EXEC: t.cycles = CYC_ONE;
      OP_BMOVE_DD, OP_BMOVE_PD: begin
        t.words  = ins.longImm ? WORDS_TWO : WORDS_ONE;
        t.cycles = ins.longImm ? CYC_THREE : CYC_TWO;
      end
      OP_BMOVE_DP: t.cycles = CYC_TWO;
      OP_PORT_IN: begin
        t.words  = WORDS_TWO;
        t.cycles = CYC_TWO;
      end
      OP_PORT_OUT: begin
        t.words  = WORDS_TWO;
        t.cycles = CYC_THREE;
      end
      OP_MAPPED_LOAD, OP_MAPPED_STORE: begin
        t.words  = WORDS_TWO;
        t.cycles = ins.periphReg ? CYC_THREE : CYC_TWO;
      end
      OP_DATA_MOVE: t.cycles = CYC_ONE;
      OP_BIT_TEST: t.cycles = CYC_ONE;
      OP_POP_ACC, OP_PUSH_ACC: t.cycles = CYC_ONE;
      OP_POP_MEM, OP_PUSH_MEM: t.cycles = CYC_ONE;
      OP_REPEAT, OP_REPEAT_BLOCK: begin
        t.words  = (ins.op == OP_REPEAT_BLOCK) ? WORDS_TWO : WORDS_ONE;
        t.cycles = CYC_TWO;
      end
      OP_REPEAT_CLEAR: begin
        t.words  = WORDS_TWO;
        t.cycles = CYC_TWO;
        t.clearAccProd = 1'b1;
      end
      default: t.cycles = CYC_ONE;
    endcase
    return t;
  endfunction

  function automatic logic usesIo(dict_op_type op);
    return (op == OP_PORT_IN) || (op == OP_PORT_OUT);
  endfunction

  // --------------------------------------------------------------------
  // instruction decode
  // --------------------------------------------------------------------
  function automatic logic isTransferOp(dict_op_type op);
    logic hit;
    case (op)
      OP_BRANCH, OP_BRANCH_ACC, OP_CALL, OP_CALL_ACC, OP_RETURN,
      OP_RETURN_CTX, OP_RETURN_CTX_IRQ, OP_SOFT_INT, OP_NMI,
      OP_BRANCH_PTR_NZ, OP_BRANCH_COND, OP_CALL_COND,
      OP_RETURN_COND: hit = 1'b1;
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic isUncondOp(dict_op_type op);
    logic hit;
    case (op)
      OP_BRANCH, OP_BRANCH_ACC, OP_CALL, OP_CALL_ACC, OP_RETURN,
      OP_RETURN_CTX, OP_RETURN_CTX_IRQ, OP_SOFT_INT,
      OP_NMI:  hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // --------------------------------------------------------------------
  // bus and wait extras
  // --------------------------------------------------------------------
  // write, turnaround and clash cycles on top of the base count
  function automatic logic [3:0] busExtra(dict_instr_type ins,
                                          logic           lastRd,
                                          logic           lastWr);
    logic [3:0] e;
    e = 4'h0;
    if (ins.extWrite) begin
      e = e + EXT_WRITE_EXTRA;
      // write against a read on either side needs a bus turnaround
      if (ins.extRead || lastRd) begin
        e = e + EXT_TURNAROUND_EXTRA;
      end
    end else if (ins.extRead && lastWr) begin
      e = e + EXT_TURNAROUND_EXTRA;
    end
    if (ins.saramClash) begin
      e = e + SARAM_CLASH_EXTRA;
    end
    return e;
  endfunction

  // wait states of the memory spaces the instruction touches
  function automatic logic [3:0] waitExtra(dict_instr_type    ins,
                                           logic [WAIT_W-1:0] pw,
                                           logic [WAIT_W-1:0] dw,
                                           logic [WAIT_W-1:0] iw,
                                           logic              extFetch);
    logic [3:0] w;
    w = 4'h0;
    if (ins.extRead || ins.extWrite) begin
      w = usesIo(ins.op) ? 4'(iw) : 4'(dw);
    end
    if (extFetch) begin
      w = w + 4'(pw);
    end
    return w;
  endfunction

  // sum saturates at 15; long wait configs are clipped, not wrapped
  function automatic logic [3:0] satSum(logic [3:0] a, logic [3:0] b,
                                        logic [3:0] c);
    logic [5:0] s;
    s = {2'h0, a} + {2'h0, b} + {2'h0, c};
    return (s > 6'h0F) ? 4'hF : s[3:0];
  endfunction

  // --------------------------------------------------------------------
  // cycle accounting
  // --------------------------------------------------------------------
  dict_timing_type base;
  logic [3:0]      extra;
  logic [3:0]      total;
  logic [3:0]      waitAdd;
  logic            accept;
  logic            lastWasRead_q;
  logic            lastWasWrite_q;
  logic [3:0]      remain_q;
  logic [3:0]      remain_d;
  logic [1:0]      slots_q;
  logic            slotsPending_q;
  logic            takeOver;
  logic            directTransfer;

  assign accept     = issueValid && issueReady;
  assign issueReady = (remain_q == 4'h0);
  assign busy       = !issueReady;

  always_comb begin
    base    = baseTiming(issueInstr);
    extra   = busExtra(issueInstr, lastWasRead_q, lastWasWrite_q);
    waitAdd = waitExtra(issueInstr, progWait, dataWait, ioWait,
                        extProgFetch);
    total   = satSum(base.cycles, extra, waitAdd);
  end

  // an accept reloads the count, which then runs down to zero
  always_comb begin
    remain_d = remain_q;
    if (accept) begin
      remain_d = total - 4'h1;
    end else if (remain_q != 4'h0) begin
      remain_d = remain_q - 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      remain_q <= 4'h0;
    end else begin
      remain_q <= remain_d;
    end
  end

  // direction of the last access, for the next turnaround
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastWasRead_q <= 1'b0;
    end else if (accept) begin
      lastWasRead_q <= issueInstr.extRead;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastWasWrite_q <= 1'b0;
    end else if (accept) begin
      lastWasWrite_q <= issueInstr.extWrite;
    end
  end

  // --------------------------------------------------------------------
  // completion report
  // --------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      doneValid <= 1'b0;
    end else begin
      doneValid <= accept;
    end
  end

  // count and size stand until the next accept
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      doneCycles <= 4'h0;
      doneWords  <= 2'h0;
    end else if (accept) begin
      doneCycles <= total;
      doneWords  <= base.words;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clearAccProd <= 1'b0;
    end else begin
      clearAccProd <= accept && base.clearAccProd;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enableIrq <= 1'b0;
    end else begin
      enableIrq <= accept && base.enableIrq;
    end
  end

  // a failed condition skips the following words, so no pulse
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      condExecNext <= 1'b0;
    end else begin
      condExecNext <= accept && (issueInstr.op == OP_COND_EXEC)
                      && issueInstr.condTrue;
    end
  end

  // --------------------------------------------------------------------
  // delayed transfers
  // --------------------------------------------------------------------
  // delayed transfer fires once the following slot words have issued
  assign takeOver = slotsPending_q && accept && (slots_q == 2'h1);
  // a plain transfer takes effect at once; slot words never transfer
  assign directTransfer = accept && !slotsPending_q && !base.flushSlots
                          && isTransferOp(issueInstr.op)
                          && (issueInstr.condTrue
                              || isUncondOp(issueInstr.op));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slots_q <= 2'h0;
    end else if (accept && slotsPending_q) begin
      slots_q <= slots_q - 2'h1;
    end else if (accept && base.flushSlots) begin
      slots_q <= 2'(DELAY_SLOT_WORDS);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slotsPending_q <= 1'b0;
    end else if (takeOver) begin
      slotsPending_q <= 1'b0;
    end else if (accept && base.flushSlots) begin
      slotsPending_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      transferNow <= 1'b0;
    end else begin
      transferNow <= takeOver || directTransfer;
    end
  end

endmodule // dict_instruction_timing

// ===== shared/dict_pkg.sv
package dict_pkg;
  // instruction classes known to the timing control
  typedef enum logic [4:0] {
    OP_NOP, OP_BRANCH, OP_BRANCH_ACC, OP_CALL, OP_CALL_ACC, OP_RETURN,
    OP_BRANCH_PTR_NZ, OP_BRANCH_COND, OP_CALL_COND, OP_RETURN_COND,
    OP_RETURN_CTX, OP_RETURN_CTX_IRQ, OP_SOFT_INT, OP_NMI, OP_COND_EXEC,
    OP_BMOVE_DD, OP_BMOVE_DP, OP_BMOVE_PD, OP_PORT_IN, OP_PORT_OUT,
    OP_MAPPED_LOAD, OP_MAPPED_STORE, OP_DATA_MOVE, OP_BIT_TEST,
    OP_POP_ACC, OP_PUSH_ACC, OP_POP_MEM, OP_PUSH_MEM,
    OP_REPEAT, OP_REPEAT_BLOCK, OP_REPEAT_CLEAR
  } dict_op_type;

  typedef struct packed {
    dict_op_type op;
    logic        delayed;    // delayed form of branch/call/return
    logic        condTrue;   // all conditions hold / pointer nonzero
    logic        longImm;    // operand from long immediate word
    logic        periphReg;  // mapped register is a peripheral one
    logic        extWrite;   // instruction writes external memory
    logic        extRead;    // instruction reads external memory
    logic        saramClash; // same single-access block touched twice
  } dict_instr_type;

  typedef struct packed {
    logic [1:0] words;
    logic [3:0] cycles;
    logic       flushSlots;  // transfer after the delay slots
    logic       clearAccProd;
    logic       enableIrq;
  } dict_timing_type;

  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [3:0] CYC_ONE   = 4'h1;
  localparam logic [3:0] CYC_TWO   = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR  = 4'h4;
  localparam logic [3:0] EXT_WRITE_EXTRA      = 4'h1;
  localparam logic [3:0] EXT_TURNAROUND_EXTRA = 4'h1;
  localparam logic [3:0] SARAM_CLASH_EXTRA    = 4'h1;
  localparam int         WAIT_WIDTH           = 3;
  localparam int         DELAY_SLOT_WORDS     = 2;
endpackage

// ===== verification/dict_ext_mem_model.sv
module dict_ext_mem_model
  import dict_pkg::*;
(
  input  wire logic                  slow,
  input  wire logic                  fetchExt,
  output logic [WAIT_WIDTH-1:0]      progWait,
  output logic [WAIT_WIDTH-1:0]      dataWait,
  output logic [WAIT_WIDTH-1:0]      ioWait,
  output logic                       extProgFetch
);
  timeunit 1ns;
  timeprecision 1ns;
  // slow memories ask for distinct counts so a mixed-up sum shows
  assign progWait     = slow ? 3'h1 : 3'h0;
  assign dataWait     = slow ? 3'h2 : 3'h0;
  assign ioWait       = slow ? 3'h3 : 3'h0;
  assign extProgFetch = fetchExt;
endmodule // dict_ext_mem_model

// ===== verification/dict_timing_properties.sv
module dict_timing_checker
  import dict_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       issueValid,
  input dict_instr_type  issueInstr,
  input wire logic       extProgFetch,
  input wire logic       issueReady,
  input wire logic       doneValid,
  input wire logic [3:0] doneCycles,
  input wire logic [1:0] doneWords,
  input wire logic       transferNow,
  input wire logic       clearAccProd,
  input wire logic       enableIrq,
  input wire logic       condExecNext
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  dict_op_type op;
  logic        acc;
  logic        pl;
  assign op  = issueInstr.op;
  assign acc = issueValid && issueReady;
  // plain: no external or clash extras on top of the base count
  assign pl  = !(issueInstr.extWrite || issueInstr.extRead ||
                 issueInstr.saramClash || extProgFetch);
  property p_done; acc |=> doneValid; endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_hold4; doneValid && doneCycles == CYC_FOUR
    |-> !issueReady [*3] ##1 issueReady; endproperty
  a_hold4: assert property (p_hold4) else $error("4 cycle hold");
  property p_br4; acc && op == OP_BRANCH && !issueInstr.delayed && pl
    |=> doneCycles == CYC_FOUR && transferNow; endproperty
  a_br4: assert property (p_br4) else $error("branch timing");
  property p_fail; acc && op == OP_BRANCH_COND && !issueInstr.condTrue
    && pl |=> doneCycles == CYC_TWO && !transferNow; endproperty
  a_fail: assert property (p_fail) else $error("failed cond");
  property p_irq; acc && op == OP_RETURN_CTX_IRQ
    |=> enableIrq && doneWords == WORDS_ONE; endproperty
  a_irq: assert property (p_irq) else $error("irq enable");
  property p_xc; acc && op == OP_COND_EXEC && pl |=> doneCycles == CYC_ONE
    && condExecNext == $past(issueInstr.condTrue); endproperty
  a_xc: assert property (p_xc) else $error("cond execute");
  property p_out; acc && op == OP_PORT_OUT && pl
    |=> doneCycles == CYC_THREE; endproperty
  a_out: assert property (p_out) else $error("port out");
  property p_one; doneValid && doneCycles == CYC_ONE |-> issueReady;
  endproperty
  a_one: assert property (p_one) else $error("single cycle");
  property p_clr; acc && op == OP_REPEAT_CLEAR
    |=> clearAccProd && doneWords == WORDS_TWO; endproperty
  a_clr: assert property (p_clr) else $error("repeat clear");
endmodule // dict_timing_checker

// ===== verification/dict_instruction_timing_tb.sv
module dict_instruction_timing_tb;
  import dict_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clock = 1'h0;
  logic           rst_b = 1'h0;
  logic           issueValid = 1'h0;
  dict_instr_type issueInstr = '0;
  logic           slow = 1'h0;
  logic           fetchExt = 1'h0;
  logic [2:0]     progWait, dataWait, ioWait;
  logic           extProgFetch, issueReady, doneValid, busy;
  logic [3:0]     doneCycles;
  logic [1:0]     doneWords;
  logic           transferNow, clearAccProd, enableIrq, condExecNext;
  int             badCount = 0;
  int             totalChecks = 0;
  int             tn = 0;
  int             cyc = 0;
  int             nClr = 0;
  int             nIrq = 0;
  int             nXc = 0;
  dict_instruction_timing u_dut (
    .clock       (clock),
    .rst_b       (rst_b),
    .issueValid  (issueValid),
    .issueInstr  (issueInstr),
    .progWait    (progWait),
    .dataWait    (dataWait),
    .ioWait      (ioWait),
    .extProgFetch(extProgFetch),
    .issueReady  (issueReady),
    .doneValid   (doneValid),
    .doneCycles  (doneCycles),
    .doneWords   (doneWords),
    .transferNow (transferNow),
    .clearAccProd(clearAccProd),
    .enableIrq   (enableIrq),
    .condExecNext(condExecNext),
    .busy        (busy)
  );
  dict_ext_mem_model u_mem (
    .slow        (slow),
    .fetchExt    (fetchExt),
    .progWait    (progWait),
    .dataWait    (dataWait),
    .ioWait      (ioWait),
    .extProgFetch(extProgFetch)
  );
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (transferNow === 1'h1) tn++;
    if (clearAccProd === 1'h1) nClr++;
    if (enableIrq === 1'h1) nIrq++;
    if (condExecNext === 1'h1) nXc++;
    if (cyc == 2000) begin
      badCount++;
      wrapUp();
    end
  end
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s exp %0d saw %0d", nm, e, g);
    end
  endtask
  // flags packed as delayed,cond,longImm,periph,write,read,clash
  task automatic chk(dict_op_type o, logic [6:0] f, logic [3:0] c,
                     logic [1:0] w);
    int n;
    n = 0;
    issueValid = 1'h1;
    issueInstr = {o, f};
    while (issueReady !== 1'h1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    issueValid = 1'h0;
    cmp(o.name(), {4'h0, c}, {4'h0, doneCycles});
    cmp("words", {6'h0, w}, {6'h0, doneWords});
    cmp("done", 8'h1, {7'h0, doneValid});
    for (n = 1; n < c; n++) begin
      cmp("ready low", 8'h0, {7'h0, issueReady});
      cmp("busy", 8'h1, {7'h0, busy});
      @(posedge clock);
      #1;
    end
    cmp("ready", 8'h1, {7'h0, issueReady});
    @(posedge clock);
    #1;
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tTransfer();
    int t0;
    t0 = tn;
    chk(OP_BRANCH, 7'h00, 4'h4, 2'h2);
    chk(OP_BRANCH_ACC, 7'h00, 4'h4, 2'h1);
    chk(OP_CALL, 7'h00, 4'h4, 2'h2);
    chk(OP_CALL_ACC, 7'h00, 4'h4, 2'h1);
    chk(OP_RETURN, 7'h00, 4'h4, 2'h1);
    chk(OP_BRANCH_PTR_NZ, 7'h20, 4'h4, 2'h2);
    chk(OP_BRANCH_PTR_NZ, 7'h00, 4'h2, 2'h2);
    chk(OP_BRANCH_COND, 7'h20, 4'h4, 2'h2);
    chk(OP_BRANCH_COND, 7'h00, 4'h2, 2'h2);
    chk(OP_CALL_COND, 7'h00, 4'h2, 2'h2);
    chk(OP_RETURN_COND, 7'h20, 4'h4, 2'h1);
    cmp("transfers", 8'(t0 + 8), 8'(tn));
    chk(OP_RETURN_CTX, 7'h00, 4'h4, 2'h1);
    chk(OP_RETURN_CTX_IRQ, 7'h00, 4'h4, 2'h1);
    chk(OP_SOFT_INT, 7'h00, 4'h4, 2'h1);
    chk(OP_NMI, 7'h00, 4'h4, 2'h1);
    cmp("irq enables", 8'h1, 8'(nIrq));
    $display("test transfer done");
  endtask
  task automatic tDelayed();
    int t0;
    t0 = tn;
    chk(OP_CALL, 7'h40, 4'h2, 2'h2);
    chk(OP_NOP, 7'h00, 4'h1, 2'h1);
    cmp("early transfer", 8'(t0), 8'(tn));
    chk(OP_NOP, 7'h00, 4'h1, 2'h1);
    cmp("slot transfer", 8'(t0 + 1), 8'(tn));
    chk(OP_BRANCH_COND, 7'h60, 4'h2, 2'h2);
    repeat (2) chk(OP_NOP, 7'h00, 4'h1, 2'h1);
    cmp("cond transfer", 8'(t0 + 2), 8'(tn));
    $display("test delayed done");
  endtask
  task automatic tMoves();
    chk(OP_BMOVE_DD, 7'h00, 4'h2, 2'h1);
    chk(OP_BMOVE_DD, 7'h10, 4'h3, 2'h2);
    chk(OP_BMOVE_DP, 7'h00, 4'h2, 2'h1);
    chk(OP_BMOVE_PD, 7'h00, 4'h2, 2'h1);
    chk(OP_BMOVE_PD, 7'h10, 4'h3, 2'h2);
    chk(OP_PORT_IN, 7'h00, 4'h2, 2'h2);
    chk(OP_PORT_OUT, 7'h00, 4'h3, 2'h2);
    chk(OP_MAPPED_LOAD, 7'h00, 4'h2, 2'h2);
    chk(OP_MAPPED_STORE, 7'h08, 4'h3, 2'h2);
    $display("test moves done");
  endtask
  task automatic tSingle();
    chk(OP_COND_EXEC, 7'h20, 4'h1, 2'h1);
    chk(OP_COND_EXEC, 7'h00, 4'h1, 2'h1);
    chk(OP_DATA_MOVE, 7'h00, 4'h1, 2'h1);
    chk(OP_BIT_TEST, 7'h00, 4'h1, 2'h1);
    chk(OP_POP_ACC, 7'h00, 4'h1, 2'h1);
    chk(OP_PUSH_ACC, 7'h00, 4'h1, 2'h1);
    chk(OP_POP_MEM, 7'h00, 4'h1, 2'h1);
    chk(OP_PUSH_MEM, 7'h00, 4'h1, 2'h1);
    chk(OP_REPEAT, 7'h00, 4'h2, 2'h1);
    chk(OP_REPEAT_BLOCK, 7'h00, 4'h2, 2'h2);
    chk(OP_REPEAT_CLEAR, 7'h00, 4'h2, 2'h2);
    cmp("cond exec", 8'h1, 8'(nXc));
    cmp("clears", 8'h1, 8'(nClr));
    $display("test single done");
  endtask
  task automatic tExternal();
    chk(OP_DATA_MOVE, 7'h04, 4'h2, 2'h1);
    chk(OP_DATA_MOVE, 7'h02, 4'h2, 2'h1);
    slow = 1'h1;
    chk(OP_DATA_MOVE, 7'h02, 4'h3, 2'h1);
    chk(OP_DATA_MOVE, 7'h04, 4'h5, 2'h1);
    slow = 1'h0;
    chk(OP_DATA_MOVE, 7'h01, 4'h2, 2'h1);
    slow = 1'h1;
    fetchExt = 1'h1;
    chk(OP_NOP, 7'h00, 4'h2, 2'h1);
    fetchExt = 1'h0;
    chk(OP_PORT_IN, 7'h02, 4'h5, 2'h2);
    slow = 1'h0;
    $display("test external done");
  endtask
  // reset in mid instruction, then a request at the first edge after
  task automatic tReset();
    issueValid = 1'h1;
    issueInstr = {OP_BRANCH, 7'h00};
    @(posedge clock);
    #1;
    issueValid = 1'h0;
    rst_b = 1'h0;
    #1;
    cmp("reset ready", 8'h1, {7'h0, issueReady});
    cmp("reset busy", 8'h0, {7'h0, busy});
    cmp("reset done", 8'h0, {7'h0, doneValid});
    cmp("reset cycles", 8'h0, {4'h0, doneCycles});
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'h1;
    chk(OP_CALL_ACC, 7'h00, 4'h4, 2'h1);
    $display("test reset done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'h1;
    tTransfer();
    tDelayed();
    tMoves();
    tSingle();
    tExternal();
    tReset();
    wrapUp();
  end
endmodule // dict_instruction_timing_tb
bind dict_instruction_timing dict_timing_checker u_chk (
  .clock       (clock),
  .rst_b       (rst_b),
  .issueValid  (issueValid),
  .issueInstr  (issueInstr),
  .extProgFetch(extProgFetch),
  .issueReady  (issueReady),
  .doneValid   (doneValid),
  .doneCycles  (doneCycles),
  .doneWords   (doneWords),
  .transferNow (transferNow),
  .clearAccProd(clearAccProd),
  .enableIrq   (enableIrq),
  .condExecNext(condExecNext)
);
